// File: hw/clock_source_consts.svh
// Offsets, field positions, reset values and counts of the main clock source control.
`ifndef CLOCK_SOURCE_CONSTS_SVH
`define CLOCK_SOURCE_CONSTS_SVH
`define MCLK_A_OFF 5'h00
`define MCLK_B_OFF 5'h01
`define MCLK_LOCK_OFF 5'h02
`define MCLK_STAT_OFF 5'h03
`define FAST_CTRL_OFF 5'h10
`define TRIM_FREQ_OFF 5'h11
`define TRIM_TEMP_OFF 5'h12
`define SLOW_CTRL_OFF 5'h18
`define XTAL_CTRL_OFF 5'h1c
`define CLOCK_OUTPUT_ENABLE_BIT 7
`define KEEP_RUNNING_IN_STANDBY_BIT 1
`define XTAL_EN_BIT 0
`define XTAL_SEL_BIT 2
`define MCLK_A_RST 8'h00
`define MCLK_B_RST 8'h11
`define CTRL_RST 8'h00
`define FUSE_FREQ_SELECT_16M 2'h1
`define ULP_GATE_EDGES 3'h4
`define XTAL_EXT_EDGES 16'h0002
`define EXT_START_EDGES 2'h2
`define SWITCH_EDGES 3'h4
`define UNLOCK_INSNS 3'h4
`define TICK_LAST 5'h1f
`endif

// File: hw/clock_source_pkg.sv
// Types shared by the main clock source control.
package clock_source_pkg;
    typedef enum logic [1:0] {
        SRC_FAST = 2'b00,
        SRC_ULP = 2'b01,
        SRC_XTAL = 2'b10,
        SRC_PIN = 2'b11
    } main_source_e;

    typedef struct packed {
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } io_req_s;

    typedef struct packed {
        logic f1;
        logic f2;
        logic f3;
        logic lvl;
        logic rise;
    } pin_sync_s;

    typedef struct packed {
        logic init;
        logic [7:0] mclk_a;
        logic [7:0] mclk_b;
        logic lock;
        logic [7:0] fast_ctrl;
        logic [6:0] trim_freq;
        logic [3:0] trim_temp;
        logic cal_lock;
        logic [7:0] slow_ctrl;
        logic [7:0] xtal_ctrl;
        logic [2:0] unlock_cnt;
        main_source_e cur_src;
        main_source_e new_src;
        logic switching;
        logic [2:0] sw_cnt;
        logic [2:0] ulp_cnt;
        logic ulp_ok;
        logic [15:0] xtal_cnt;
        logic xtal_ok;
        logic [1:0] ext_cnt;
        logic ext_ok;
        logic [4:0] tick_cnt;
        logic tick;
        logic [6:0] ratio;
        logic [6:0] pre_cnt;
        logic per_en;
        logic per_tog;
        logic clock_output_enable;
        logic [7:0] rdata;
    } ctrl_state_s;
endpackage

// File: hw/main_clock_source_control.sv
// Main clock source selection, prescaler, oscillator start-up gating and protected registers.
`timescale 1ns/100ps
`default_nettype none
`include "clock_source_consts.svh"
module main_clock_source_control
    import clock_source_pkg::*;
#(
    parameter logic [15:0] XTAL_SU0 = 16'h0100,
    parameter logic [15:0] XTAL_SU1 = 16'h0400,
    parameter logic [15:0] XTAL_SU2 = 16'h0800,
    parameter logic [15:0] XTAL_SU3 = 16'h1000,
    parameter logic [6:0] TRIM16_FREQ = 7'h40,
    parameter logic [3:0] TRIM16_TEMP = 4'h8,
    parameter logic [6:0] TRIM20_FREQ = 7'h40,
    parameter logic [3:0] TRIM20_TEMP = 4'h8,
    parameter logic [7:0] ERR_16M_LOW = 8'h00,
    parameter logic [7:0] ERR_16M_HIGH = 8'h00,
    parameter logic [7:0] ERR_20M_LOW = 8'h00,
    parameter logic [7:0] ERR_20M_HIGH = 8'h00
)
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // I/O register port and protection strobes.
    input wire io_req_s io_req_i,
    output logic [7:0] io_rdata_o,
    input wire logic ccp_key_i,
    input wire logic insn_done_i,
    // Fuses.
    input wire logic [1:0] fuse_freq_select_i,
    input wire logic fuse_osc_lock_i,
    // Oscillator and clock pins.
    input wire logic ulp_osc_i,
    input wire logic ulp_analog_ready_i,
    input wire logic crystal_pin_in_i,
    input wire logic pin_external_clock_i,
    // Clock requests and sleep state.
    input wire logic ulp_req_i,
    input wire logic xtal_req_i,
    input wire logic ext_req_i,
    input wire logic sleep_i,
    input wire logic sysclk_in_use_i,
    // Signature error read port.
    input wire logic [1:0] sig_sel_i,
    output logic [7:0] sig_err_o,
    output logic [10:0] sig_err_q110_o,
    // Clock results and pin configuration.
    output main_source_e main_source_o,
    output logic main_en_o,
    output logic per_en_o,
    output logic slow_tick_o,
    output logic clock_output_o,
    output logic crystal_pins_override_o,
    output logic pin_ext_input_o,
    output logic [6:0] fast_osc_freq_trim_o,
    output logic [3:0] fast_osc_temp_trim_o
);
    ctrl_state_s r, nxt;
    logic ulp_lvl, ulp_rise, ana_lvl, xtal_rise, ext_rise;
    logic unlocked, cfg_ok, cal_ok, main_edge, old_edge, new_edge;
    logic ulp_want, xtal_want, ext_want;
    logic [6:0] code_ratio;
    logic [15:0] xtal_need;
    // Division code to ratio; zero marks a reserved code.
    function automatic logic [6:0] div_ratio(input logic [3:0] code);
        case (code)
            4'h0: div_ratio = 7'h02;
            4'h1: div_ratio = 7'h04;
            4'h2: div_ratio = 7'h08;
            4'h3: div_ratio = 7'h10;
            4'h4: div_ratio = 7'h20;
            4'h5: div_ratio = 7'h40;
            4'h8: div_ratio = 7'h06;
            4'h9: div_ratio = 7'h0a;
            4'ha: div_ratio = 7'h0c;
            4'hb: div_ratio = 7'h18;
            4'hc: div_ratio = 7'h30;
            default: div_ratio = 7'h00;
        endcase
    endfunction
    // Gated edge of one source as seen on the system clock.
    function automatic logic src_edge(input main_source_e s, input logic u, input logic x, input logic e);
        case (s)
            SRC_FAST: src_edge = 1'b1;
            SRC_ULP: src_edge = u;
            SRC_XTAL: src_edge = x;
            default: src_edge = e;
        endcase
    endfunction
    // Pin synchronisers.
    pin_edge_sync u_ulp (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pin_i(ulp_osc_i),
        .level_o(ulp_lvl), .rise_o(ulp_rise));
    pin_edge_sync u_ana (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pin_i(ulp_analog_ready_i),
        .level_o(ana_lvl), .rise_o());
    pin_edge_sync u_xtal (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pin_i(crystal_pin_in_i),
        .level_o(), .rise_o(xtal_rise));
    pin_edge_sync u_ext (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pin_i(pin_external_clock_i),
        .level_o(), .rise_o(ext_rise));
    // Write permissions, source requests and gated edges.
    always_comb
    begin
        unlocked = (r.unlock_cnt != 3'h0);
        cfg_ok = unlocked & ~r.lock;
        cal_ok = unlocked & ~r.cal_lock & ~(r.lock & (r.cur_src == SRC_FAST));
        ulp_want = ulp_req_i | r.slow_ctrl[`KEEP_RUNNING_IN_STANDBY_BIT] | (r.cur_src == SRC_ULP)
            | (r.switching & (r.new_src == SRC_ULP));
        xtal_want = r.xtal_ctrl[`XTAL_EN_BIT] & (xtal_req_i | r.xtal_ctrl[`KEEP_RUNNING_IN_STANDBY_BIT]
            | (r.cur_src == SRC_XTAL) | (r.switching & (r.new_src == SRC_XTAL)));
        ext_want = ext_req_i | (r.cur_src == SRC_PIN) | (r.switching & (r.new_src == SRC_PIN));
        old_edge = src_edge(r.cur_src, ulp_rise & r.ulp_ok, xtal_rise & r.xtal_ok, ext_rise & r.ext_ok);
        new_edge = src_edge(r.new_src, ulp_rise & r.ulp_ok, xtal_rise & r.xtal_ok, ext_rise & r.ext_ok);
        main_edge = old_edge;
        code_ratio = div_ratio(r.mclk_b[4:1]);
        case (r.xtal_ctrl[5:4])
            2'h0: xtal_need = XTAL_SU0;
            2'h1: xtal_need = XTAL_SU1;
            2'h2: xtal_need = XTAL_SU2;
            default: xtal_need = XTAL_SU3;
        endcase
        if (r.xtal_ctrl[`XTAL_SEL_BIT])
            xtal_need = `XTAL_EXT_EDGES;
    end
    // Next-state logic.
    always_comb
    begin
        nxt = r;
        nxt.init = 1'b0;
        nxt.tick = 1'b0;
        nxt.per_en = 1'b0;
        // Factory trims follow the fuse frequency select once after reset.
        if (r.init)
        begin
            nxt.trim_freq = (fuse_freq_select_i == `FUSE_FREQ_SELECT_16M) ? TRIM16_FREQ : TRIM20_FREQ;
            nxt.trim_temp = (fuse_freq_select_i == `FUSE_FREQ_SELECT_16M) ? TRIM16_TEMP : TRIM20_TEMP;
            nxt.lock = fuse_osc_lock_i;
            nxt.cal_lock = fuse_osc_lock_i;
        end
        // Unlock window: the key opens it, instruction strobes run it down.
        if (ccp_key_i)
            nxt.unlock_cnt = `UNLOCK_INSNS;
        else if (insn_done_i && unlocked)
            nxt.unlock_cnt = r.unlock_cnt - 3'h1;
        // Protected register writes.
        if (io_req_i.wr && !r.init)
        begin
            case (io_req_i.addr)
                `MCLK_A_OFF:
                    if (cfg_ok)
                    begin
                        nxt.mclk_a[`CLOCK_OUTPUT_ENABLE_BIT] = io_req_i.wdata[`CLOCK_OUTPUT_ENABLE_BIT];
                        if (!r.switching)
                        begin
                            nxt.mclk_a[1:0] = io_req_i.wdata[1:0];
                            if (main_source_e'(io_req_i.wdata[1:0]) != r.cur_src)
                            begin
                                nxt.switching = 1'b1;
                                nxt.new_src = main_source_e'(io_req_i.wdata[1:0]);
                                nxt.sw_cnt = 3'h0;
                            end
                        end
                    end
                `MCLK_B_OFF:
                    if (cfg_ok)
                        nxt.mclk_b = {3'h0, io_req_i.wdata[4:0]};
                `MCLK_LOCK_OFF:
                    if (cfg_ok)
                        nxt.lock = io_req_i.wdata[0];
                `FAST_CTRL_OFF:
                    if (unlocked)
                        nxt.fast_ctrl = {6'h00, io_req_i.wdata[`KEEP_RUNNING_IN_STANDBY_BIT], 1'b0};
                `TRIM_FREQ_OFF:
                    if (cal_ok)
                        nxt.trim_freq = io_req_i.wdata[6:0];
                `TRIM_TEMP_OFF:
                    if (cal_ok)
                        nxt.trim_temp = io_req_i.wdata[3:0];
                `SLOW_CTRL_OFF:
                    if (unlocked)
                        nxt.slow_ctrl = {6'h00, io_req_i.wdata[`KEEP_RUNNING_IN_STANDBY_BIT], 1'b0};
                `XTAL_CTRL_OFF:
                    if (unlocked)
                    begin
                        nxt.xtal_ctrl[1:0] = io_req_i.wdata[1:0];
                        // Select and start-up time are frozen while enabled or stable.
                        if (!r.xtal_ctrl[`XTAL_EN_BIT] && !r.xtal_ok)
                        begin
                            nxt.xtal_ctrl[`XTAL_SEL_BIT] = io_req_i.wdata[`XTAL_SEL_BIT];
                            nxt.xtal_ctrl[5:4] = io_req_i.wdata[5:4];
                        end
                    end
                default: ;
            endcase
        end
        // Slow oscillator: analog start-up, then four more edges.
        if (!ulp_want || !ana_lvl)
        begin
            nxt.ulp_cnt = 3'h0;
            nxt.ulp_ok = 1'b0;
        end
        else if (!r.ulp_ok && ulp_rise)
        begin
            nxt.ulp_cnt = r.ulp_cnt + 3'h1;
            nxt.ulp_ok = (r.ulp_cnt + 3'h1 == `ULP_GATE_EDGES);
        end
        // Crystal oscillator start-up.
        if (!xtal_want)
        begin
            nxt.xtal_cnt = 16'h0000;
            nxt.xtal_ok = 1'b0;
        end
        else if (!r.xtal_ok && xtal_rise)
        begin
            nxt.xtal_cnt = r.xtal_cnt + 16'h0001;
            nxt.xtal_ok = (r.xtal_cnt + 16'h0001 >= xtal_need);
        end
        // Pin external clock start-up.
        if (!ext_want)
        begin
            nxt.ext_cnt = 2'h0;
            nxt.ext_ok = 1'b0;
        end
        else if (!r.ext_ok && ext_rise)
        begin
            nxt.ext_cnt = r.ext_cnt + 2'h1;
            nxt.ext_ok = (r.ext_cnt + 2'h1 == `EXT_START_EDGES);
        end
        // Source switch: count new edges, then commit on an old-source edge.
        if (r.switching)
        begin
            if (r.sw_cnt != `SWITCH_EDGES)
            begin
                if (new_edge)
                    nxt.sw_cnt = r.sw_cnt + 3'h1;
            end
            else if (old_edge)
            begin
                nxt.cur_src = r.new_src;
                nxt.switching = 1'b0;
            end
        end
        // Slow tick divides the slow oscillator by 32.
        if (ulp_rise && r.ulp_ok)
        begin
            nxt.tick_cnt = r.tick_cnt + 5'h01;
            nxt.tick = (r.tick_cnt == `TICK_LAST);
        end
        // Prescaler on main clock edges; a reserved code keeps the last ratio.
        if (code_ratio != 7'h00)
            nxt.ratio = code_ratio;
        if (main_edge)
        begin
            if (!r.mclk_b[0] || (r.pre_cnt + 7'h01 >= r.ratio))
            begin
                nxt.pre_cnt = 7'h00;
                nxt.per_en = 1'b1;
            end
            else
                nxt.pre_cnt = r.pre_cnt + 7'h01;
        end
        if (r.per_en)
            nxt.per_tog = ~r.per_tog;
        nxt.clock_output_enable = r.mclk_a[`CLOCK_OUTPUT_ENABLE_BIT] & (~sleep_i | sysclk_in_use_i) & r.per_tog;
        // Register read data, answered one cycle after the address.
        case (io_req_i.addr)
            `MCLK_A_OFF: nxt.rdata = r.mclk_a;
            `MCLK_B_OFF: nxt.rdata = r.mclk_b;
            `MCLK_LOCK_OFF: nxt.rdata = {7'h00, r.lock};
            `MCLK_STAT_OFF: nxt.rdata = {r.ext_ok, r.xtal_ok, r.ulp_ok, 1'b1, 3'h0, r.switching};
            `FAST_CTRL_OFF: nxt.rdata = r.fast_ctrl;
            `TRIM_FREQ_OFF: nxt.rdata = {1'b0, r.trim_freq};
            `TRIM_TEMP_OFF: nxt.rdata = {r.cal_lock, 3'h0, r.trim_temp};
            `SLOW_CTRL_OFF: nxt.rdata = r.slow_ctrl;
            `XTAL_CTRL_OFF: nxt.rdata = r.xtal_ctrl;
            default: nxt.rdata = 8'h00;
        endcase
    end
    // State register; reset selects the fast oscillator with divide by six.
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r <= '0;
            r.init <= 1'b1;
            r.mclk_a <= `MCLK_A_RST;
            r.mclk_b <= `MCLK_B_RST;
            r.ratio <= 7'h06;
            r.cur_src <= SRC_FAST;
            r.new_src <= SRC_FAST;
        end
        else
            r <= nxt;
    end
    // Signature errors and their Q1.10 expansion.
    always_comb
    begin
        case (sig_sel_i)
            2'h0: sig_err_o = ERR_16M_LOW;
            2'h1: sig_err_o = ERR_16M_HIGH;
            2'h2: sig_err_o = ERR_20M_LOW;
            default: sig_err_o = ERR_20M_HIGH;
        endcase
        sig_err_q110_o = {{4{sig_err_o[7]}}, sig_err_o[6:0]};
    end
    // Outputs.
    assign io_rdata_o = r.rdata;
    assign main_source_o = r.cur_src;
    assign main_en_o = main_edge;
    assign per_en_o = r.per_en;
    assign slow_tick_o = r.tick;
    assign clock_output_o = r.clock_output_enable;
    assign crystal_pins_override_o = r.xtal_ctrl[`XTAL_EN_BIT];
    assign pin_ext_input_o = ext_want;
    assign fast_osc_freq_trim_o = r.trim_freq;
    assign fast_osc_temp_trim_o = r.trim_temp;
    // Checks.
    sequence s_locked_write;
        io_req_i.wr && !r.init && r.unlock_cnt == 3'h0 && io_req_i.addr == `MCLK_B_OFF;
    endsequence
    sequence s_busy_select;
        r.switching && r.sw_cnt != `SWITCH_EDGES && io_req_i.wr && io_req_i.addr == `MCLK_A_OFF;
    endsequence
    a_locked_write_kept: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_locked_write |=> $stable(r.mclk_b)) else $error("locked write changed control B");
    a_reset_divide_six: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        r.init |-> r.mclk_b == 8'h11 && r.cur_src == SRC_FAST) else $error("bad reset clock setup");
    a_window_closes: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        r.unlock_cnt == 3'h1 && insn_done_i && !ccp_key_i |=> r.unlock_cnt == 3'h0)
        else $error("unlock window stayed open");
    a_slow_gate_count: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(r.ulp_ok) |-> r.ulp_cnt == 3'h4 && $past(ana_lvl)) else $error("slow clock opened early");
    a_xtal_needs_enable: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !r.xtal_ctrl[0] |=> !r.xtal_ok) else $error("crystal stable while disabled");
    a_ext_two_edges: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(r.ext_ok) |-> r.ext_cnt == 2'h2) else $error("pin clock started early");
    a_bypass_prescale: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !r.mclk_b[0] && main_edge |=> per_en_o) else $error("undivided clock missed");
    a_sleep_no_clock_output_enable: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sleep_i && !sysclk_in_use_i |=> !clock_output_o) else $error("clock output during sleep");
    a_switch_frozen: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_busy_select |=> $stable(r.new_src) && r.switching) else $error("source changed mid switch");
endmodule
`default_nettype wire

// File: hw/pin_edge_sync.sv
// Three-stage pin synchroniser with settled level and rising-edge pulse.
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync
    import clock_source_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Pin and result.
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o
);
    pin_sync_s r, nxt;

    // The level changes only once the second and third stages agree.
    always_comb
    begin
        nxt = r;
        nxt.f1 = pin_i;
        nxt.f2 = r.f1;
        nxt.f3 = r.f2;
        nxt.rise = 1'b0;
        if (r.f2 == r.f3)
        begin
            nxt.lvl = r.f3;
            nxt.rise = r.f3 & ~r.lvl;
        end
    end

    // State register.
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
            r <= '0;
        else
            r <= nxt;
    end

    assign level_o = r.lvl;
    assign rise_o = r.rise;
endmodule
`default_nettype wire

// File: test/clock_pin_partner.sv
// Behavioural model of the crystal and external clock sources on the pins.
`timescale 1ns/100ps
`default_nettype none
module clock_pin_partner
(
    // Pin takeover from the block.
    input wire logic xtal_run_i,
    // Pin clocks.
    output logic crystal_pin_in_o,
    output logic pin_external_clock_o
);
    // The crystal swings only while its pins are taken over, and rests low when stopped.
    initial crystal_pin_in_o = 1'b0;
    always #173 crystal_pin_in_o = xtal_run_i ? ~crystal_pin_in_o : 1'b0;
    // The external clock runs free, unrelated in phase to the system clock.
    initial pin_external_clock_o = 1'b0;
    always #211 pin_external_clock_o = ~pin_external_clock_o;
endmodule
`default_nettype wire

// File: test/main_clock_source_control_tb.sv
// Self-checking testbench of the main clock source control.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module main_clock_source_control_tb
    import clock_source_pkg::*;
;
    // Stimulus, all set at time zero.
    logic clk_sys_i = 0, reset_i = 1, ccp_key_i = 0, insn_done_i = 0, fuse_osc_lock_i = 0, ulp_osc_i = 0;
    logic ulp_analog_ready_i = 0, ulp_req_i = 0, xtal_req_i = 0, ext_req_i = 0, sleep_i = 0, sysclk_in_use_i = 0;
    logic [1:0] fuse_freq_select_i = 2'h1, sig_sel_i = 2'h0;
    io_req_s io_req_i = '0;
    // Observed outputs and pin clocks.
    logic [7:0] io_rdata_o, sig_err_o;
    logic [10:0] sig_err_q110_o;
    main_source_e main_source_o;
    logic main_en_o, per_en_o, slow_tick_o, clock_output_o, crystal_pins_override_o, pin_ext_input_o;
    logic crystal_pin_in_i, pin_external_clock_i;
    logic [6:0] fast_osc_freq_trim_o;
    logic [3:0] fast_osc_temp_trim_o;
    int fails = 0, compares = 0, n;

    // The 20 MHz clock and a free-running slow oscillator.
    always #25 clk_sys_i = ~clk_sys_i;
    always #130 ulp_osc_i = ~ulp_osc_i;

    // Block with distinct 16 MHz trims and stored errors; crystal start-up counts stay at their defaults.
    main_clock_source_control #(.TRIM16_FREQ(7'h2a), .TRIM16_TEMP(4'h5), .ERR_16M_LOW(8'h85), .ERR_16M_HIGH(8'h12),
        .ERR_20M_LOW(8'h7f)) DUT (.clk_sys_i, .reset_i, .io_req_i, .io_rdata_o, .ccp_key_i, .insn_done_i,
        .fuse_freq_select_i, .fuse_osc_lock_i, .ulp_osc_i, .ulp_analog_ready_i, .crystal_pin_in_i,
        .pin_external_clock_i, .ulp_req_i, .xtal_req_i, .ext_req_i, .sleep_i, .sysclk_in_use_i, .sig_sel_i,
        .sig_err_o, .sig_err_q110_o, .main_source_o, .main_en_o, .per_en_o, .slow_tick_o, .clock_output_o,
        .crystal_pins_override_o, .pin_ext_input_o, .fast_osc_freq_trim_o, .fast_osc_temp_trim_o);
    // Far-side clock sources.
    clock_pin_partner peer (.xtal_run_i(crystal_pins_override_o), .crystal_pin_in_o(crystal_pin_in_i),
        .pin_external_clock_o(pin_external_clock_i));

    // Waits for k rising edges and settles just after the last one.
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask

    // Register write, optionally after the unlock key in its own cycle.
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic k);
        if (k)
        begin
            ccp_key_i = 1;
            step(1);
            ccp_key_i = 0;
        end
        io_req_i = '{1'b1, a, d};
        step(1);
        io_req_i.wr = 0;
    endtask

    // Register read; the data is taken after the edge and masked.
    task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
        io_req_i.addr = a;
        step(1);
        `CHK(io_rdata_o & m, e)
    endtask

    // Counts pulses of one output, or toggles of the clock output, over k cycles.
    task automatic cnt(input int k, input int s);
        logic p;
        n = 0;
        p = clock_output_o;
        repeat (k)
        begin
            step(1);
            n += s == 0 ? per_en_o : s == 1 ? main_en_o : s == 2 ? slow_tick_o : clock_output_o !== p;
            p = clock_output_o;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Reset values, fuse trims and the default divide by six.
    task automatic t_reset;
        rd(5'h00, 8'hff, 8'h00);
        rd(5'h01, 8'hff, 8'h11);
        `CHK(main_source_o, SRC_FAST)
        `CHK(fast_osc_freq_trim_o, 7'h2a)
        rd(5'h12, 8'hff, 8'h05);
        cnt(960, 0);
        `CHK(n, 160)
        $display("reset done");
    endtask

    // Stored errors and their widened fixed-point form.
    task automatic t_sig;
        logic [7:0] e[4] = '{8'h85, 8'h12, 8'h7f, 8'h00};
        logic [10:0] q[4] = '{11'h785, 11'h012, 11'h07f, 11'h000};
        for (int i = 0; i < 4; i++)
        begin
            sig_sel_i = 2'(i);
            step(1);
            `CHK(sig_err_o, e[i])
            `CHK(sig_err_q110_o, q[i])
        end
        $display("signature done");
    endtask

    // Writes without key, after an expired window, and with a fresh key.
    task automatic t_lock;
        wr(5'h01, 8'h00, 0);
        rd(5'h01, 8'hff, 8'h11);
        ccp_key_i = 1;
        step(1);
        ccp_key_i = 0;
        insn_done_i = 1;
        step(4);
        insn_done_i = 0;
        wr(5'h10, 8'h02, 0);
        rd(5'h10, 8'hff, 8'h00);
        wr(5'h10, 8'h02, 1);
        rd(5'h10, 8'hff, 8'h02);
        $display("lock done");
    endtask

    // Every division code, a reserved one last, then the bypass.
    task automatic t_div;
        logic [3:0] c[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h6};
        int r[12] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 48};
        for (int i = 0; i < 12; i++)
        begin
            wr(5'h01, {3'h0, c[i], 1'b1}, 1);
            cnt(70, 0);
            cnt(960, 0);
            `CHK(n, 960 / r[i])
        end
        wr(5'h01, 8'h0a, 1);
        cnt(4, 0);
        cnt(20, 0);
        `CHK(n, 20)
        $display("prescaler done");
    endtask

    // Clock output on, silenced in sleep, back while the clock is in use.
    task automatic t_clock_output_enable;
        wr(5'h00, 8'h80, 1);
        cnt(20, 3);
        `CHK(n > 0, 1'b1)
        sleep_i = 1;
        cnt(3, 3);
        cnt(20, 3);
        `CHK(n, 0)
        sysclk_in_use_i = 1;
        cnt(3, 3);
        cnt(20, 3);
        `CHK(n > 0, 1'b1)
        sleep_i = 0;
        wr(5'h00, 8'h00, 1);
        $display("clock output done");
    endtask

    // Switch to the pin clock; a second select while switching is ignored.
    task automatic t_pin;
        ext_req_i = 1;
        step(1);
        `CHK(pin_ext_input_o, 1'b1)
        step(40);
        rd(5'h03, 8'h80, 8'h80);
        wr(5'h00, 8'h03, 1);
        step(2);
        rd(5'h03, 8'h01, 8'h01);
        wr(5'h00, 8'h01, 1);
        for (int i = 0; i < 300 && main_source_o !== SRC_PIN; i++)
            step(1);
        `CHK(main_source_o, SRC_PIN)
        rd(5'h03, 8'h01, 8'h00);
        cnt(90, 1);
        `CHK(n inside {[6:13]}, 1'b1)
        $display("switch done");
    endtask

    // Crystal enabled but not requested, then requested, then restarted as a crystal with its start-up count.
    task automatic t_xtal;
        wr(5'h1c, 8'h05, 1);
        step(2);
        `CHK(crystal_pins_override_o, 1'b1)
        step(60);
        rd(5'h03, 8'h40, 8'h00);
        xtal_req_i = 1;
        step(60);
        rd(5'h03, 8'h40, 8'h40);
        wr(5'h1c, 8'h00, 1);
        step(2);
        wr(5'h1c, 8'h01, 1);
        step(1000);
        rd(5'h03, 8'h40, 8'h00);
        step(1000);
        rd(5'h03, 8'h40, 8'h40);
        $display("crystal done");
    endtask

    // Slow oscillator gated until analog ready, then the slow tick at one per 32 oscillator edges.
    task automatic t_ulp;
        ulp_req_i = 1;
        step(60);
        rd(5'h03, 8'h20, 8'h00);
        ulp_analog_ready_i = 1;
        step(60);
        rd(5'h03, 8'h20, 8'h20);
        cnt(400, 2);
        `CHK(n inside {[2:3]}, 1'b1)
        $display("slow oscillator done");
    endtask

    // A second reset with 20 MHz trims and the fuse lock set.
    task automatic t_rereset;
        fuse_freq_select_i = 2'h2;
        fuse_osc_lock_i = 1;
        reset_i = 1;
        step(4);
        reset_i = 0;
        step(2);
        `CHK(main_source_o, SRC_FAST)
        `CHK(fast_osc_freq_trim_o, 7'h40)
        rd(5'h12, 8'hff, 8'h88);
        wr(5'h01, 8'h03, 1);
        rd(5'h01, 8'hff, 8'h11);
        $display("second reset done");
    endtask

    // Reset for four cycles, then the scenarios in turn.
    initial
    begin
        step(4);
        reset_i = 0;
        step(2);
        t_reset;
        t_sig;
        t_lock;
        t_div;
        t_clock_output_enable;
        t_pin;
        t_xtal;
        t_ulp;
        t_rereset;
        tally_and_finish;
    end

    // The scenarios take about 16300 cycles; the watchdog allows 40000.
    initial
    begin
        #2000000;
        fails++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
